/* logic/tmpcs_pkg.sv */
// constants shared by the timer mode, pin and clock select block
// assumes a 32-bit apb slave clocked by the fast peripheral clock
package tmpcs_pkg;
    // ------------------------------------------------------------
    // structure
    // ------------------------------------------------------------
    localparam int NTMR = 3;
    localparam int WD_IDX = 2;
    localparam int ADDR_W = 8;
    localparam int CTL_W = 10;
    // ------------------------------------------------------------
    // register offsets (bytes)
    // ------------------------------------------------------------
    localparam logic [7:0] TMR_STRIDE = 8'h20;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_PRD_LO = 8'h04;
    localparam logic [7:0] OFF_PRD_HI = 8'h08;
    localparam logic [7:0] OFF_CNT_LO = 8'h0c;
    localparam logic [7:0] OFF_CNT_HI = 8'h10;
    localparam logic [7:0] OFF_SIGSEL = 8'h60;
    localparam logic [7:0] OFF_CLKSPD = 8'h64;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h68;
    localparam logic [7:0] OFF_IRQ_CLR = 8'h6c;
    localparam logic [7:0] OFF_IRQ_EN = 8'h70;
    localparam logic [7:0] OFF_PIN_DATA = 8'h74;
    localparam logic [7:0] OFF_WD_CTRL = 8'h78;
    // ------------------------------------------------------------
    // fields
    // ------------------------------------------------------------
    localparam int CTL_CFG_LSB = 0;
    localparam int CTL_EN = 2;
    localparam int CTL_CONT = 3;
    localparam int CTL_CP = 4;
    localparam int CTL_PW_LSB = 5;
    localparam int CTL_PF_LSB = 7;
    localparam int SEL_RT_LSB = 3;
    localparam int PIN_OUT_LSB = 4;
    localparam int IRQ_WD = 3;
    localparam int IRQ_W = 4;
    localparam logic [CTL_W-1:0] CTRL_RST = 10'h000;
    localparam logic [3:0] CLK_DIV = 4'h0;
    // ------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CFG_64 = 2'h0, CFG_CHAIN = 2'h1, CFG_UNCHAIN = 2'h2, CFG_WDOG = 2'h3
    } tmpcs_cfg_t;
    typedef enum logic [2:0] {
        PF_GPIN = 3'h0, PF_EXTCLK = 3'h1, PF_GATE = 3'h2,
        PF_TOUT = 3'h3, PF_GPOUT = 3'h4
    } tmpcs_pf_t;
    typedef enum logic [1:0] {
        RT_NMI = 2'h0, RT_RESET = 2'h1, RT_EXT_IRQ_THREE = 2'h2
    } tmpcs_route_t;
endpackage

/* logic/tmpcs_sync.sv */
// two-stage synchroniser with rising edge detect for one timer pin
// assumes the pin is asynchronous to ref_clk
`timescale 1ns/1ps
module tmpcs_sync (
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // pin and synchronised copies
    input wire logic pin_in,
    output logic level,
    output logic rise
);
    logic meta_ff;
    logic sync_ff;
    logic prev_ff;

    // first stage feeds only the second stage
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            prev_ff <= 1'b0;
        end else begin
            meta_ff <= pin_in;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    assign level = sync_ff;
    assign rise = sync_ff & ~prev_ff;
endmodule

/* logic/tmpcs_core.sv */
// counting core of one timer: 64-bit, chained or unchained 32-bit
// assumes tick is a one-cycle enable already built by the caller
`timescale 1ns/1ps
module tmpcs_core (
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // configuration
    input wire logic tick,
    input wire logic enable,
    input wire logic cont,
    input wire logic cp,
    input wire logic [1:0] pulse_width_field,
    input wire logic [1:0] cfg,
    input wire logic [63:0] period,
    // state and events
    output logic [63:0] count,
    output logic match,
    output logic tout
);
    logic [31:0] lo_ff;
    logic [31:0] hi_ff;
    logic done_ff;
    logic tout_ff;
    logic [1:0] pw_ff;
    logic wide;
    logic chain;
    logic hit;
    logic pre_hit;
    logic step;

    assign wide = (cfg == tmpcs_pkg::CFG_64);
    assign chain = (cfg == tmpcs_pkg::CFG_CHAIN);
    assign pre_hit = (hi_ff == period[63:32]);
    assign hit = wide ? ({hi_ff, lo_ff} == period) : (lo_ff == period[31:0]);
    assign step = tick & enable & ~done_ff;
    assign match = step & hit & (wide | ~chain | pre_hit);
    assign count = {hi_ff, lo_ff};
    assign tout = tout_ff;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            lo_ff <= 32'h0000_0000;
            hi_ff <= 32'h0000_0000;
            done_ff <= 1'b0;
        end else if (!enable) begin
            lo_ff <= 32'h0000_0000;
            hi_ff <= 32'h0000_0000;
            done_ff <= 1'b0;
        end else if (step) begin
            if (wide) begin
                if (hit) begin
                    {hi_ff, lo_ff} <= 64'h0;
                    done_ff <= ~cont;
                end else begin
                    {hi_ff, lo_ff} <= {hi_ff, lo_ff} + 64'h1;
                end
            end else if (chain) begin
                // high half prescales the low half
                if (pre_hit) begin
                    hi_ff <= 32'h0000_0000;
                    lo_ff <= hit ? 32'h0000_0000 : lo_ff + 32'h1;
                    done_ff <= hit & ~cont;
                end else begin
                    hi_ff <= hi_ff + 32'h1;
                end
            end else begin
                hi_ff <= pre_hit ? 32'h0000_0000 : hi_ff + 32'h1;
                lo_ff <= hit ? 32'h0000_0000 : lo_ff + 32'h1;
                done_ff <= hit & ~cont;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            tout_ff <= 1'b0;
            pw_ff <= 2'h0;
        end else if (match) begin
            tout_ff <= cp ? ~tout_ff : 1'b1;
            pw_ff <= pulse_width_field;
        end else if (tick && !cp && tout_ff) begin
            if (pw_ff == 2'h0) begin
                tout_ff <= 1'b0;
            end else begin
                pw_ff <= pw_ff - 2'h1;
            end
        end
    end
endmodule

/* logic/tmpcs_top.sv */
// timer mode, pin and clock select shell for three 64-bit timers
// assumes an apb master on ref_clk and asynchronous timer pins
`timescale 1ns/1ps
module tmpcs_top (
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // timer pins: two gp timers then the watchdog pin
    input wire logic [2:0] pin_i,
    output logic [2:0] pin_o,
    output logic [2:0] pin_oe,
    // events and interrupt lines
    output logic [2:0] timer_event,
    output logic irq,
    output logic nmi_n,
    output logic sys_reset_n,
    output logic ext_irq_three_n
);
    localparam int N = tmpcs_pkg::NTMR;
    localparam int W = tmpcs_pkg::CTL_W;

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [W-1:0] ctrl_ff [N];
    logic [63:0] prd_ff [N];
    logic [4:0] sigsel_ff;
    logic [2:0] out_val_ff;
    logic watchdog_enable_bit_ff;
    logic [3:0] irq_stat_ff;
    logic [3:0] irq_en_ff;
    logic [3:0] div_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [2:0] pin_o_ff;
    logic [2:0] pin_oe_ff;
    logic [2:0] evt_ff;
    logic irq_ff;
    logic nmi_n_ff;
    logic rst_n_ff;
    logic ext_irq_three_n_ff;

    // ------------------------------------------------------------
    // per-timer wiring
    // ------------------------------------------------------------
    logic [2:0] lvl;
    logic [2:0] rise;
    logic [2:0] tick;
    logic [2:0] hit;
    logic [2:0] tout;
    logic [63:0] cnt [N];
    logic [1:0] eff_cfg [N];
    logic [2:0] nxt_pin_o;
    logic wd_active;
    logic wd_hit;
    logic div_tick;
    logic [3:0] irq_set;

    function automatic logic [2:0] pf_of(input logic [W-1:0] c);
        pf_of = c[tmpcs_pkg::CTL_PF_LSB +: 3];
    endfunction

    function automatic logic [1:0] cfg_of(input logic [W-1:0] c);
        cfg_of = c[tmpcs_pkg::CTL_CFG_LSB +: 2];
    endfunction

    // ------------------------------------------------------------
    // internal timer clock
    // ------------------------------------------------------------
    // divider on fast clock
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            div_ff <= 4'h0;
        end else if (div_tick) begin
            div_ff <= 4'h0;
        end else begin
            div_ff <= div_ff + 4'h1;
        end
    end
    assign div_tick = (div_ff == tmpcs_pkg::CLK_DIV);

    // watchdog only when third timer set to it and enabled
    // watchdog role select
    assign wd_active = (cfg_of(ctrl_ff[tmpcs_pkg::WD_IDX])
                        == tmpcs_pkg::CFG_WDOG) && watchdog_enable_bit_ff;
    assign wd_hit = wd_active & hit[tmpcs_pkg::WD_IDX];

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_tmr
            logic pin_in_q;
            logic [2:0] pf;
            assign pf = pf_of(ctrl_ff[g]);
            tmpcs_sync u_sync (
                .ref_clk(ref_clk),
                .arst_n(arst_n),
                .pin_in(pin_i[g]),
                .level(lvl[g]),
                .rise(rise[g])
            );
            assign pin_in_q = ~sigsel_ff[g];
            always_comb begin
                if (pin_in_q && pf == tmpcs_pkg::PF_EXTCLK) begin
                    tick[g] = rise[g];
                end else if (pin_in_q && pf == tmpcs_pkg::PF_GATE) begin
                    tick[g] = div_tick & lvl[g];
                end else begin
                    tick[g] = div_tick;
                end
            end
            // gp timers fall back to 64-bit
            assign eff_cfg[g] = (cfg_of(ctrl_ff[g]) == tmpcs_pkg::CFG_WDOG)
                                ? tmpcs_pkg::CFG_64 : cfg_of(ctrl_ff[g]);
            tmpcs_core u_core (
                .ref_clk(ref_clk),
                .arst_n(arst_n),
                .tick(tick[g]),
                .enable(ctrl_ff[g][tmpcs_pkg::CTL_EN]),
                .cont(ctrl_ff[g][tmpcs_pkg::CTL_CONT]),
                .cp(ctrl_ff[g][tmpcs_pkg::CTL_CP]),
                .pulse_width_field(ctrl_ff[g][tmpcs_pkg::CTL_PW_LSB +: 2]),
                .cfg(eff_cfg[g]),
                .period(prd_ff[g]),
                .count(cnt[g]),
                .match(hit[g]),
                .tout(tout[g])
            );
            assign nxt_pin_o[g] = (pf == tmpcs_pkg::PF_GPOUT)
                                  ? out_val_ff[g] : tout[g];
        end
    endgenerate

    // ------------------------------------------------------------
    // pins
    // ------------------------------------------------------------
    // pin direction for all three pins, watchdog pin included
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_o_ff <= 3'h0;
            pin_oe_ff <= 3'h0;
        end else begin
            pin_o_ff <= nxt_pin_o & sigsel_ff[2:0];
            pin_oe_ff <= sigsel_ff[2:0];
        end
    end

    // ------------------------------------------------------------
    // events and watchdog routing
    // ------------------------------------------------------------
    // watchdog interrupt routing
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            evt_ff <= 3'h0;
            nmi_n_ff <= 1'b1;
            rst_n_ff <= 1'b1;
            ext_irq_three_n_ff <= 1'b1;
        end else begin
            evt_ff <= hit & {~wd_active, 2'b11};
            nmi_n_ff <= ~(wd_hit && sigsel_ff[tmpcs_pkg::SEL_RT_LSB +: 2]
                          == tmpcs_pkg::RT_NMI);
            rst_n_ff <= ~(wd_hit && sigsel_ff[tmpcs_pkg::SEL_RT_LSB +: 2]
                          == tmpcs_pkg::RT_RESET);
            ext_irq_three_n_ff <= ~(wd_hit && sigsel_ff[tmpcs_pkg::SEL_RT_LSB +: 2]
                           == tmpcs_pkg::RT_EXT_IRQ_THREE);
        end
    end

    // ------------------------------------------------------------
    // apb access
    // ------------------------------------------------------------
    logic setup;
    logic wr;
    logic [2:0] sel_t;
    logic [7:0] off_t;
    logic [31:0] rd_val;
    logic rd_ok;

    assign setup = psel & ~penable;
    assign wr = psel & penable & pwrite & pready_ff;
    assign off_t = paddr - {1'b0, paddr[6:5], 5'h00};
    assign sel_t = (paddr < tmpcs_pkg::OFF_SIGSEL)
                   ? (3'h1 << paddr[6:5]) : 3'h0;
    assign irq_set = {wd_hit, hit & {~wd_active, 2'b11}};

    always_comb begin
        rd_val = 32'h0000_0000;
        rd_ok = 1'b1;
        if (sel_t != 3'h0 && paddr[1:0] == 2'h0) begin
            unique case (off_t)
                tmpcs_pkg::OFF_CTRL:
                    rd_val = {22'h0, ctrl_ff[paddr[6:5]]};
                tmpcs_pkg::OFF_PRD_LO: rd_val = prd_ff[paddr[6:5]][31:0];
                tmpcs_pkg::OFF_PRD_HI: rd_val = prd_ff[paddr[6:5]][63:32];
                tmpcs_pkg::OFF_CNT_LO: rd_val = cnt[paddr[6:5]][31:0];
                tmpcs_pkg::OFF_CNT_HI: rd_val = cnt[paddr[6:5]][63:32];
                default: rd_ok = 1'b0;
            endcase
        end else begin
            unique case (paddr)
                tmpcs_pkg::OFF_SIGSEL: rd_val = {27'h0, sigsel_ff};
                tmpcs_pkg::OFF_CLKSPD: rd_val = {28'h0, tmpcs_pkg::CLK_DIV};
                tmpcs_pkg::OFF_IRQ_STAT: rd_val = {28'h0, irq_stat_ff};
                tmpcs_pkg::OFF_IRQ_CLR: rd_val = 32'h0000_0000;
                tmpcs_pkg::OFF_IRQ_EN: rd_val = {28'h0, irq_en_ff};
                tmpcs_pkg::OFF_PIN_DATA:
                    rd_val = {25'h0, out_val_ff, 1'b0, lvl & ~sigsel_ff[2:0]};
                tmpcs_pkg::OFF_WD_CTRL: rd_val = {31'h0, watchdog_enable_bit_ff};
                default: rd_ok = 1'b0;
            endcase
        end
    end

    // answer in the first access cycle
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            pready_ff <= setup;
            pslverr_ff <= setup & ~rd_ok;
            prdata_ff <= (setup && !pwrite) ? rd_val : 32'h0000_0000;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < N; i++) begin
                ctrl_ff[i] <= tmpcs_pkg::CTRL_RST;
                prd_ff[i] <= 64'h0;
            end
            sigsel_ff <= 5'h00;
            out_val_ff <= 3'h0;
            watchdog_enable_bit_ff <= 1'b0;
            irq_en_ff <= 4'h0;
        end else if (wr && !pslverr_ff) begin
            for (int i = 0; i < N; i++) begin
                if (sel_t[i] && off_t == tmpcs_pkg::OFF_CTRL) begin
                    ctrl_ff[i] <= pwdata[W-1:0];
                end
                if (sel_t[i] && off_t == tmpcs_pkg::OFF_PRD_LO) begin
                    prd_ff[i][31:0] <= pwdata;
                end
                if (sel_t[i] && off_t == tmpcs_pkg::OFF_PRD_HI) begin
                    prd_ff[i][63:32] <= pwdata;
                end
            end
            if (paddr == tmpcs_pkg::OFF_SIGSEL) begin
                sigsel_ff <= pwdata[4:0];
            end
            if (paddr == tmpcs_pkg::OFF_PIN_DATA) begin
                out_val_ff <= pwdata[tmpcs_pkg::PIN_OUT_LSB +: 3];
            end
            if (paddr == tmpcs_pkg::OFF_WD_CTRL) begin
                watchdog_enable_bit_ff <= pwdata[0];
            end
            if (paddr == tmpcs_pkg::OFF_IRQ_EN) begin
                irq_en_ff <= pwdata[3:0];
            end
        end
    end

    // ------------------------------------------------------------
    // interrupt status
    // ------------------------------------------------------------
    // set beats a clear in the same cycle
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_stat_ff <= 4'h0;
            irq_ff <= 1'b0;
        end else begin
            if (wr && !pslverr_ff && paddr == tmpcs_pkg::OFF_IRQ_CLR) begin
                irq_stat_ff <= (irq_stat_ff & ~pwdata[3:0]) | irq_set;
            end else begin
                irq_stat_ff <= irq_stat_ff | irq_set;
            end
            irq_ff <= |(irq_stat_ff & irq_en_ff);
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign pin_o = pin_o_ff;
    assign pin_oe = pin_oe_ff;
    assign timer_event = evt_ff;
    assign irq = irq_ff;
    assign nmi_n = nmi_n_ff;
    assign sys_reset_n = rst_n_ff;
    assign ext_irq_three_n = ext_irq_three_n_ff;
endmodule

/* bench/tmpcs_assertions.sv */
// checker: apb answer, pin drive and watchdog line behaviour
// assumes binding onto tmpcs_top, seeing its ports only
`timescale 1ns/1ps
module tmpcs_assertions (
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // pins and lines
    input wire logic [2:0] pin_o,
    input wire logic [2:0] pin_oe,
    input wire logic nmi_n,
    input wire logic sys_reset_n,
    input wire logic ext_irq_three_n
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    // ----
    // helpers
    // ----
    logic [2:0] dir_ff;
    logic sel_wr;
    logic [2:0] low;
    assign sel_wr = psel && penable && pready && pwrite
        && paddr == tmpcs_pkg::OFF_SIGSEL;
    assign low = ~{nmi_n, sys_reset_n, ext_irq_three_n};
    // last written direction bits, the only legal source of pin_oe
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            dir_ff <= 3'h0;
        end else if (sel_wr) begin
            dir_ff <= pwdata[2:0];
        end
    end
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence rd_div_s;
        psel && penable && pready && !pwrite
            && paddr == tmpcs_pkg::OFF_CLKSPD;
    endsequence
    answer_next_a: assert property (setup_s |=> pready)
        else $error("no ready after setup");
    ready_once_a: assert property (pready |=> !pready)
        else $error("ready held two cycles");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    divisor_zero_a: assert property (rd_div_s |->
        prdata == 32'h0 && !pslverr) else $error("divisor not zero");
    oe_follow_a: assert property (sel_wr |->
        ##[1:2] pin_oe == dir_ff) else $error("pin enable lags");
    oe_source_a: assert property ($changed(pin_oe) |->
        pin_oe == dir_ff) else $error("pin enable moved alone");
    drive_idle_a: assert property (
        (pin_o & ~pin_oe) == 3'h0) else $error("undriven pin has value");
    route_one_a: assert property ($onehot0(low))
        else $error("two watchdog lines at once");
    route_pulse_a: assert property (low != 3'h0 |=>
        low == 3'h0) else $error("watchdog line held");
endmodule
bind tmpcs_top tmpcs_assertions tmpcs_assertions_inst (
    .ref_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .pin_o, .pin_oe, .nmi_n, .sys_reset_n,
    .ext_irq_three_n
);

/* bench/tmpcs_pin_model.sv */
// far side: timer pin wires and the three watchdog lines
// assumes the bench sets the level driven on released pins
`timescale 1ns/1ps
module tmpcs_pin_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // pin wires
    input wire logic [2:0] pin_o,
    input wire logic [2:0] pin_oe,
    input wire logic [2:0] drv_lvl,
    output logic [2:0] pin_i,
    // interrupt lines, pulses counted per line
    input wire logic nmi_n,
    input wire logic sys_reset_n,
    input wire logic ext_irq_three_n,
    output logic [7:0] hits [3]
);
    // wire level
    // device drive wins; the far side holds its level otherwise
    assign pin_i = (pin_o & pin_oe) | (drv_lvl & ~pin_oe);
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            hits <= '{8'h0, 8'h0, 8'h0};
        end else begin
            hits[0] <= hits[0] + {7'h0, ~nmi_n};
            hits[1] <= hits[1] + {7'h0, ~sys_reset_n};
            hits[2] <= hits[2] + {7'h0, ~ext_irq_three_n};
        end
    end
endmodule

/* bench/tmpcs_tb_top.sv */
// self-checking bench for the timer mode, pin and clock select shell
// assumes the pin model closes the pin wires and counts line pulses
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin \
    err_count++; $display("wrong value %s exp %0h got %0h", nm, ex, gt); \
    end end
module tmpcs_tb_top;
    typedef struct {
        logic [7:0] a;
        logic w;
        logic [31:0] d;
        logic [31:0] e;
        logic x;
    } tmpcs_row_t;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0;
    logic [2:0] drv_lvl = 3'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, er, irq, nmi_n, sys_reset_n, ext_irq_three_n;
    logic [2:0] pin_i, pin_o, pin_oe, timer_event;
    logic [7:0] hits [3];
    int err_count = 0;
    int cmp_count = 0;
    int n, m;
    // reset reads first: the mid-run reset reuses rows 0 to 3
    tmpcs_row_t rows [11] = '{
        '{8'h00, 1'b0, 32'h0, 32'h0, 1'b0},
        '{8'h20, 1'b0, 32'h0, 32'h0, 1'b0},
        '{8'h40, 1'b0, 32'h0, 32'h0, 1'b0},
        '{8'h78, 1'b0, 32'h0, 32'h0, 1'b0},
        '{8'h64, 1'b1, 32'hffffffff, 32'h0, 1'b0},
        '{8'h04, 1'b1, 32'h12345678, 32'h12345678, 1'b0},
        '{8'h28, 1'b1, 32'ha5a5a5a5, 32'ha5a5a5a5, 1'b0},
        '{8'h00, 1'b1, 32'h1, 32'h1, 1'b0},
        '{8'h20, 1'b1, 32'h2, 32'h2, 1'b0},
        '{8'h6c, 1'b1, 32'hf, 32'h0, 1'b0},
        '{8'hfc, 1'b1, 32'h1, 32'h0, 1'b1}};
    always #2.5 ref_clk = ~ref_clk;
    tmpcs_top tmpcs_top_inst (.ref_clk, .arst_n, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .pin_i, .pin_o,
        .pin_oe, .timer_event, .irq, .nmi_n, .sys_reset_n, .ext_irq_three_n);
    tmpcs_pin_model tmpcs_pin_model_inst (.ref_clk, .arst_n, .pin_o,
        .pin_oe, .drv_lvl, .pin_i, .nmi_n, .sys_reset_n, .ext_irq_three_n,
        .hits);
    task automatic tally_and_finish();
        if (err_count == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // s: 0-2 pin wire, 3 timer zero event, 4 pready; k edges waited
    task automatic wait_for(input int s, input logic v, output int k);
        k = 0;
        while ((s == 4 ? pready : s == 3 ? timer_event[0] : pin_i[s[1:0]])
                !== v && k < 50) begin
            @(posedge ref_clk);
            k++;
        end
        if (k >= 50) begin
            err_count++;
            tally_and_finish();
        end
    endtask
    task automatic cyc(input int c);
        repeat (c) @(posedge ref_clk);
    endtask
    // idle edge at the end so psel is never assigned twice in one step
    task automatic apb(input logic [7:0] a, input logic w,
            input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        wait_for(4, 1'b1, k);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    initial begin
        repeat (20) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        foreach (rows[i]) begin
            if (rows[i].w)
                apb(rows[i].a, 1'b1, rows[i].d);
            apb(rows[i].a, 1'b0, 32'h0);
            `CHK("reg read", rows[i].e, rd)
            `CHK("reg error", rows[i].x, er)
        end
        // ----
        // period, pulse width and interrupt
        // ----
        apb(8'h04, 1'b1, 32'h5);
        apb(8'h60, 1'b1, 32'h1);
        apb(8'h00, 1'b1, 32'h1ec);
        wait_for(3, 1'b1, n);
        wait_for(3, 1'b0, n);
        wait_for(3, 1'b1, m);
        `CHK("event gap", 6, n + m)
        wait_for(0, 1'b0, n);
        wait_for(0, 1'b1, n);
        wait_for(0, 1'b0, n);
        `CHK("pulse width", 4, n)
        apb(8'h68, 1'b0, 32'h0);
        `CHK("status", 1'b1, rd[0])
        `CHK("irq masked", 1'b0, irq)
        apb(8'h70, 1'b1, 32'h1);
        cyc(2);
        `CHK("irq raised", 1'b1, irq)
        apb(8'h00, 1'b1, 32'h0);
        apb(8'h6c, 1'b1, 32'h1);
        cyc(2);
        `CHK("irq cleared", 1'b0, irq)
        // ----
        // chained, unchained and toggle modes
        // ----
        apb(8'h08, 1'b1, 32'h1);
        for (int c = 1; c < 3; c++) begin
            apb(8'h00, 1'b1, 32'hc | c);
            wait_for(3, 1'b1, n);
            wait_for(3, 1'b0, n);
            wait_for(3, 1'b1, m);
            `CHK("cfg gap", c == 1 ? 12 : 6, n + m)
            apb(8'h00, 1'b1, 32'h0);
        end
        apb(8'h08, 1'b1, 32'h0);
        apb(8'h00, 1'b1, 32'h1c);
        wait_for(0, 1'b1, n);
        wait_for(0, 1'b0, n);
        `CHK("toggle width", 6, n)
        apb(8'h00, 1'b1, 32'h0);
        // ----
        // pin as input, output and clock
        // ----
        for (int v = 1; v >= 0; v--) begin
            drv_lvl <= {1'b0, v[0], 1'b0};
            cyc(4);
            apb(8'h74, 1'b0, 32'h0);
            `CHK("gp in", v[0], rd[1])
        end
        apb(8'h60, 1'b1, 32'h7);
        apb(8'h20, 1'b1, 32'h200);
        apb(8'h74, 1'b1, 32'h20);
        cyc(1);
        `CHK("gp out", 2'h3, {pin_oe[1], pin_i[1]})
        `CHK("wd pin out", 1'b1, pin_oe[2])
        apb(8'h74, 1'b0, 32'h0);
        `CHK("pin data", 7'h20, rd[6:0])
        apb(8'h60, 1'b1, 32'h1);
        apb(8'h24, 1'b1, 32'h100);
        apb(8'h20, 1'b1, 32'h84);
        repeat (5) begin
            drv_lvl <= 3'h2;
            cyc(4);
            drv_lvl <= 3'h0;
            cyc(4);
        end
        cyc(6);
        apb(8'h2c, 1'b0, 32'h0);
        `CHK("ext edges", 32'h5, rd)
        apb(8'h20, 1'b1, 32'h104);
        drv_lvl <= 3'h2;
        cyc(10);
        drv_lvl <= 3'h0;
        cyc(6);
        apb(8'h2c, 1'b0, 32'h0);
        `CHK("gated count", 32'hf, rd)
        // ----
        // watchdog role and routing
        // ----
        apb(8'h44, 1'b1, 32'h3);
        apb(8'h78, 1'b1, 32'h1);
        for (int r = 0; r < 3; r++) begin
            apb(8'h40, 1'b1, 32'h0);
            apb(8'h60, 1'b1, 32'h1 | (r << 3));
            apb(8'h40, 1'b1, 32'h7);
            cyc(12);
            `CHK("route", 8'h1, hits[r])
        end
        apb(8'h68, 1'b0, 32'h0);
        `CHK("wd status", 2'h2, rd[3:2])
        apb(8'h6c, 1'b1, 32'hf);
        apb(8'h00, 1'b1, 32'h7);
        cyc(12);
        apb(8'h68, 1'b0, 32'h0);
        `CHK("gp wd mode", 4'h1, rd[3:0])
        `CHK("no route", 8'h1, hits[0])
        arst_n <= 1'b0;
        cyc(20);
        arst_n <= 1'b1;
        cyc(1);
        `CHK("pins input", 3'h0, pin_oe)
        for (int i = 0; i < 4; i++) begin
            apb(rows[i].a, 1'b0, 32'h0);
            `CHK("reset read", 32'h0, rd)
        end
        tally_and_finish();
    end
endmodule
